// [dv/dal_monitor_model.sv]
// Behavioural model of the drive fault monitors and the checksum and defaults indications
`default_nettype none
module dal_monitor_model (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Requests from the bench
    input wire logic [5:0] fault_req,
    input wire logic [2:0] sum_req,
    input wire logic restore_req,
    // Lines toward the alarm latch
    output logic [5:0] fault_lines,
    output logic [2:0] sum_lines,
    output logic restore_pulse
);
    timeunit 1ns;
    timeprecision 1ns;
    // Causes change just after an edge and hold while the fault lasts
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            fault_lines <= 6'h00;
            sum_lines <= 3'h0;
            restore_pulse <= 1'b0;
        end else begin
            fault_lines <= fault_req;
            sum_lines <= sum_req;
            restore_pulse <= restore_req;
        end
    end
endmodule
`default_nettype wire

// [dv/drive_alarm_latch_tb.sv]
// Self-checking bench for the drive alarm latch
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin mismatches++; \
    $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module drive_alarm_latch_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import dal_pkg::*;
    // ==========================================================
    // Stimulus and observed signals
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic [5:0] fault_req = 6'h00;
    logic [2:0] sum_req = 3'h0;
    logic restore_req = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    wire [5:0] fl;
    wire [2:0] sl;
    wire rp;
    wire [31:0] reg_rdata;
    wire drive_lock;
    wire drive_healthy_flag;
    wire [3:0] active_alarm_code;
    wire [3:0] last_alarm_record;
    wire irq;
    int mismatches = 0;
    int compares = 0;
    int cycles = 0;
    int j;
    int k;
    logic [3:0] code;
    // ==========================================================
    // Instances
    dal_monitor_model mon (.clk_sys(clk_sys), .resetn(resetn), .fault_req(fault_req),
        .sum_req(sum_req), .restore_req(restore_req), .fault_lines(fl), .sum_lines(sl),
        .restore_pulse(rp));
    dal_core dut (.clk_sys(clk_sys), .resetn(resetn), .overvolt_in(fl[0]),
        .low_supply_fault(fl[1]), .overcurr_in(fl[2]), .resolver_in(fl[3]),
        .motor_temp_in(fl[4]), .conv_temp_in(fl[5]), .plc_sum_err(sl[0]),
        .param_sum_err(sl[1]), .defaults_loaded(sl[2]), .restore_defaults_cmd(rp),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .drive_lock(drive_lock),
        .drive_healthy_flag(drive_healthy_flag), .active_alarm_code(active_alarm_code),
        .last_alarm_record(last_alarm_record), .irq(irq));
    // ==========================================================
    // Clock and hang guard
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            $display("[FAIL] %0t run did not finish", $time);
            end_of_test();
        end
    end
    // ==========================================================
    // Bus, wait and check helpers
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        `CHK(reg_rdata, e)
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic fault(input logic [5:0] f);
        @(posedge clk_sys);
        fault_req <= f;
    endtask
    task automatic see(input logic [3:0] act, input logic [3:0] lst);
        `CHK(active_alarm_code, act)
        `CHK(last_alarm_record, lst)
        `CHK(drive_healthy_flag, act == DAL_CODE_NONE)
        `CHK(drive_lock, act != DAL_CODE_NONE)
    endtask
    task automatic clr();
        wr(DAL_OFS_CTRL, 32'h1);
        idle(2);
    endtask
    // Expected record: undervoltage never overwrites it
    function automatic logic [3:0] rec(input logic [3:0] c, input logic [3:0] prev);
        return (c == DAL_CODE_UNDERVOLT) ? prev : c;
    endfunction
    task automatic end_of_test();
        if (mismatches == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        void'($urandom(86));
        repeat (10) @(posedge clk_sys);
        resetn <= 1'b1;
        idle(1);
        see(DAL_CODE_NONE, DAL_CODE_NONE);
        rd(DAL_OFS_CTRL, 32'h0);
        rd(DAL_OFS_IRQ_MASK, 32'h0);
        rd(8'h20, 32'h0);
        // Each monitor fault trips, ignores a later fault, outlives its cause
        for (int i = 0; i < 6; i++) begin
            code = 4'(i + 1);
            fault(6'h01 << i);
            k = 0;
            while (drive_lock !== 1'b1 && k < 6) begin
                idle(1);
                k++;
            end
            `CHK(drive_lock, 1'b1)
            idle(4);
            see(code, rec(code, DAL_CODE_NONE));
            j = $urandom_range(5, 0);
            fault((6'h01 << i) | (6'h01 << j));
            idle(8);
            `CHK(active_alarm_code, code)
            fault(6'h00);
            idle(8 + $urandom_range(7, 0));
            `CHK(active_alarm_code, code)
            `CHK(drive_lock, 1'b1)
            clr();
            see(DAL_CODE_NONE, DAL_CODE_NONE);
        end
        // Reset command with the cause still present trips again
        fault(6'h04);
        idle(8);
        clr();
        idle(2);
        see(DAL_CODE_OVERCURR, DAL_CODE_OVERCURR);
        rd(DAL_OFS_CTRL, 32'h0);
        fault(6'h00);
        idle(8);
        clr();
        // Undervoltage auto-clear
        wr(DAL_OFS_CTRL, 32'h2);
        rd(DAL_OFS_CTRL, 32'h2);
        fault(6'h02);
        idle(8);
        see(DAL_CODE_UNDERVOLT, DAL_CODE_NONE);
        fault(6'h00);
        idle(8);
        see(DAL_CODE_NONE, DAL_CODE_NONE);
        wr(DAL_OFS_CTRL, 32'h0);
        // Interrupt: pending events, mask, write-one-to-clear
        idle(1);
        `CHK(irq, 1'b0)
        wr(DAL_OFS_IRQ_MASK, 32'h1);
        idle(1);
        `CHK(irq, 1'b1)
        rd(DAL_OFS_IRQ_STAT, 32'h3);
        wr(DAL_OFS_IRQ_STAT, 32'h3);
        rd(DAL_OFS_IRQ_STAT, 32'h0);
        `CHK(irq, 1'b0)
        // User alarms from the program, cleared by command only
        wr(DAL_OFS_CTRL, 32'h4);
        idle(2);
        see(DAL_CODE_USER_FIRST, DAL_CODE_USER_FIRST);
        `CHK(irq, 1'b1)
        rd(DAL_OFS_STATUS, 32'h2);
        wr(DAL_OFS_IRQ_MASK, 32'h0);
        idle(1);
        `CHK(irq, 1'b0)
        clr();
        wr(DAL_OFS_CTRL, 32'h8);
        idle(2);
        see(DAL_CODE_USER_SECOND, DAL_CODE_USER_SECOND);
        clr();
        see(DAL_CODE_NONE, DAL_CODE_NONE);
        // Checksum codes refuse reset until defaults are restored
        for (int s = 0; s < 2; s++) begin
            code = DAL_CODE_PLC_SUM + 4'(s);
            @(posedge clk_sys);
            sum_req <= 3'(1 << s);
            idle(3);
            see(code, code);
            clr();
            `CHK(active_alarm_code, code)
            @(posedge clk_sys);
            sum_req <= 3'h0;
            clr();
            `CHK(active_alarm_code, code)
            @(posedge clk_sys);
            restore_req <= 1'b1;
            @(posedge clk_sys);
            restore_req <= 1'b0;
            idle(3);
            `CHK(active_alarm_code, DAL_CODE_DEFAULTS)
            clr();
            see(DAL_CODE_NONE, DAL_CODE_NONE);
        end
        @(posedge clk_sys);
        sum_req <= 3'h4;
        idle(3);
        `CHK(active_alarm_code, DAL_CODE_DEFAULTS)
        @(posedge clk_sys);
        sum_req <= 3'h0;
        clr();
        // Power cycle clears a latched alarm
        wr(DAL_OFS_CTRL, 32'h4);
        idle(2);
        see(DAL_CODE_USER_FIRST, DAL_CODE_USER_FIRST);
        @(posedge clk_sys);
        resetn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        idle(2);
        see(DAL_CODE_NONE, DAL_CODE_NONE);
        end_of_test();
    end
endmodule
`default_nettype wire

// [pkg/dal_pkg.sv]
// Package for the drive alarm latch: codes, register map and reset values
`default_nettype none
package dal_pkg;
    // ==========================================================
    // Alarm codes
    localparam logic [3:0] DAL_CODE_NONE = 4'h0;
    localparam logic [3:0] DAL_CODE_OVERVOLT = 4'h1;
    localparam logic [3:0] DAL_CODE_UNDERVOLT = 4'h2;
    localparam logic [3:0] DAL_CODE_OVERCURR = 4'h3;
    localparam logic [3:0] DAL_CODE_RESOLVER = 4'h4;
    localparam logic [3:0] DAL_CODE_MOTOR_TEMP = 4'h5;
    localparam logic [3:0] DAL_CODE_CONV_TEMP = 4'h6;
    localparam logic [3:0] DAL_CODE_USER_FIRST = 4'h7;
    localparam logic [3:0] DAL_CODE_USER_SECOND = 4'h8;
    localparam logic [3:0] DAL_CODE_PLC_SUM = 4'ha;
    localparam logic [3:0] DAL_CODE_PARAM_SUM = 4'hb;
    localparam logic [3:0] DAL_CODE_DEFAULTS = 4'hf;
    // ==========================================================
    // Register offsets (byte addresses of 32-bit words)
    localparam logic [7:0] DAL_OFS_CTRL = 8'h00;
    localparam logic [7:0] DAL_OFS_ACTIVE = 8'h04;
    localparam logic [7:0] DAL_OFS_LAST = 8'h08;
    localparam logic [7:0] DAL_OFS_STATUS = 8'h0c;
    localparam logic [7:0] DAL_OFS_IRQ_STAT = 8'h10;
    localparam logic [7:0] DAL_OFS_IRQ_MASK = 8'h14;
    // ==========================================================
    // Control register bit positions
    localparam int DAL_BIT_RESET_CMD = 0;
    localparam int DAL_BIT_UV_AUTO = 1;
    localparam int DAL_BIT_USER_FIRST = 2;
    localparam int DAL_BIT_USER_SECOND = 3;
    // Interrupt status bit positions
    localparam int DAL_IRQ_TRIP = 0;
    localparam int DAL_IRQ_CLEARED = 1;
    localparam int DAL_IRQ_W = 2;
    // ==========================================================
    // Reset values
    localparam logic DAL_RST_UV_AUTO = 1'b0;
    localparam logic [DAL_IRQ_W-1:0] DAL_RST_IRQ_MASK = 2'h0;
endpackage
`default_nettype wire

// [rtl/dal_core.sv]
// Latching alarm manager for a servo drive with register port and interrupt
// How it works
// - Drive lock rises in the same cycle a checksum, user or defaults condition is present, four cycles after a monitor input rises
// - Active alarm code register shows the tripped alarm's code
// - Each new alarm is recorded as last alarm, except undervoltage
// - Tripped alarm stays latched after its cause goes; only reset, power or undervoltage auto-clear clears
// - Alarm reset command sets active code and last record to zero
// - Reset command self-clears; a persisting condition trips again at once
// - Reset ignored while a checksum code is active; restore defaults first
// - Undervoltage auto-clear resets to 0; when 1 undervoltage clears itself
// - Two user alarm bits lock the drive and clear only by reset command
// - Healthy flag is 1 with no alarm latched and no cause present, else 0
// - Codes: 0 none, 1..6 monitor faults, 7 and 8 user alarms
// - Code 10 PLC checksum, 11 parameter checksum, 15 defaults loaded
// - Logic power-up reset clears every latched alarm
`default_nettype none
module dal_core
    import dal_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Fault monitor inputs, asynchronous levels
    input wire logic overvolt_in,
    input wire logic low_supply_fault,
    input wire logic overcurr_in,
    input wire logic resolver_in,
    input wire logic motor_temp_in,
    input wire logic conv_temp_in,
    // Checksum and defaults indications from the drive's own logic
    input wire logic plc_sum_err,
    input wire logic param_sum_err,
    input wire logic defaults_loaded,
    input wire logic restore_defaults_cmd,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Drive outputs
    output logic drive_lock,
    output logic drive_healthy_flag,
    output logic [3:0] active_alarm_code,
    output logic [3:0] last_alarm_record,
    output logic irq
);
    localparam int NSYNC = 6;

    typedef struct packed {
        logic [NSYNC-1:0] s1;
        logic [NSYNC-1:0] s2;
        logic [NSYNC-1:0] s3;
        logic [NSYNC-1:0] flt;
        logic [3:0] active;
        logic [3:0] last;
        logic uv_auto;
        logic user_first;
        logic user_second;
        logic [DAL_IRQ_W-1:0] irq_stat;
        logic [DAL_IRQ_W-1:0] irq_mask;
        logic [31:0] rdata;
    } dal_state_t;

    dal_state_t st_reg, st_next;
    logic [NSYNC-1:0] raw_in;
    logic [3:0] cause;
    logic reset_cmd;
    logic reset_ok;
    logic [DAL_IRQ_W-1:0] ev;

    assign raw_in = {conv_temp_in, motor_temp_in, resolver_in,
                     overcurr_in, low_supply_fault, overvolt_in};
    assign reset_cmd = reg_wr && (reg_addr == DAL_OFS_CTRL) && reg_wdata[DAL_BIT_RESET_CMD];
    assign reset_ok = reset_cmd && (st_reg.active != DAL_CODE_PLC_SUM)
                      && (st_reg.active != DAL_CODE_PARAM_SUM);

    // ==========================================================
    // Highest-priority present cause, checksum conditions first
    always_comb begin
        cause = DAL_CODE_NONE;
        if (param_sum_err) begin
            cause = DAL_CODE_PARAM_SUM;
        end else if (plc_sum_err) begin
            cause = DAL_CODE_PLC_SUM;
        end else if (st_reg.flt[0]) begin
            cause = DAL_CODE_OVERVOLT;
        end else if (st_reg.flt[1]) begin
            cause = DAL_CODE_UNDERVOLT;
        end else if (st_reg.flt[2]) begin
            cause = DAL_CODE_OVERCURR;
        end else if (st_reg.flt[3]) begin
            cause = DAL_CODE_RESOLVER;
        end else if (st_reg.flt[4]) begin
            cause = DAL_CODE_MOTOR_TEMP;
        end else if (st_reg.flt[5]) begin
            cause = DAL_CODE_CONV_TEMP;
        end else if (st_reg.user_first) begin
            cause = DAL_CODE_USER_FIRST;
        end else if (st_reg.user_second) begin
            cause = DAL_CODE_USER_SECOND;
        end else if (defaults_loaded) begin
            cause = DAL_CODE_DEFAULTS;
        end
    end

    // ==========================================================
    // Next-state logic
    always_comb begin
        st_next = st_reg;
        ev = '0;
        // Three-stage synchroniser, change accepted when stages 2 and 3 agree
        st_next.s1 = raw_in;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        for (int i = 0; i < NSYNC; i++) begin
            if (st_reg.s2[i] == st_reg.s3[i]) begin
                st_next.flt[i] = st_reg.s3[i];
            end
        end
        // Control register writes
        if (reg_wr && reg_addr == DAL_OFS_CTRL) begin
            st_next.uv_auto = reg_wdata[DAL_BIT_UV_AUTO];
            if (reg_wdata[DAL_BIT_USER_FIRST]) begin
                st_next.user_first = 1'b1;
            end
            if (reg_wdata[DAL_BIT_USER_SECOND]) begin
                st_next.user_second = 1'b1;
            end
        end
        if (reg_wr && reg_addr == DAL_OFS_IRQ_MASK) begin
            st_next.irq_mask = reg_wdata[DAL_IRQ_W-1:0];
        end
        // Reset command: pulse only, nothing stored, so it self-clears
        if (reset_ok) begin
            st_next.active = DAL_CODE_NONE;
            st_next.last = DAL_CODE_NONE;
            st_next.user_first = 1'b0;
            st_next.user_second = 1'b0;
            ev[DAL_IRQ_CLEARED] = 1'b1;
        end else if (st_reg.uv_auto && st_reg.active == DAL_CODE_UNDERVOLT
                     && !st_reg.flt[1]) begin
            st_next.active = DAL_CODE_NONE;
            ev[DAL_IRQ_CLEARED] = 1'b1;
        end else if (st_reg.active == DAL_CODE_NONE && cause != DAL_CODE_NONE) begin
            st_next.active = cause;
            if (cause != DAL_CODE_UNDERVOLT) begin
                st_next.last = cause;
            end
            ev[DAL_IRQ_TRIP] = 1'b1;
        end
        // Restore defaults lifts a checksum latch so the reset can act
        if (restore_defaults_cmd && !param_sum_err && !plc_sum_err
            && (st_reg.active == DAL_CODE_PLC_SUM
                || st_reg.active == DAL_CODE_PARAM_SUM)) begin
            st_next.active = DAL_CODE_DEFAULTS;
        end
        // Sticky interrupt status: set wins over write-one-to-clear
        if (reg_wr && reg_addr == DAL_OFS_IRQ_STAT) begin
            st_next.irq_stat = st_reg.irq_stat & ~reg_wdata[DAL_IRQ_W-1:0];
        end
        st_next.irq_stat = st_next.irq_stat | ev;
        // Read data, one cycle after the strobe
        st_next.rdata = '0;
        if (reg_rd) begin
            unique case (reg_addr)
                DAL_OFS_CTRL: st_next.rdata = {28'h0, st_reg.user_second,
                                               st_reg.user_first, st_reg.uv_auto, 1'b0};
                DAL_OFS_ACTIVE: st_next.rdata = {28'h0, st_reg.active};
                DAL_OFS_LAST: st_next.rdata = {28'h0, st_reg.last};
                DAL_OFS_STATUS: st_next.rdata = {30'h0, drive_lock, drive_healthy_flag};
                DAL_OFS_IRQ_STAT: st_next.rdata = {30'h0, st_reg.irq_stat};
                DAL_OFS_IRQ_MASK: st_next.rdata = {30'h0, st_reg.irq_mask};
                default: st_next.rdata = '0;
            endcase
        end
    end

    // ==========================================================
    // State register, cleared at logic power-up
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            st_reg <= '0;
            st_reg.uv_auto <= DAL_RST_UV_AUTO;
            st_reg.irq_mask <= DAL_RST_IRQ_MASK;
        end else begin
            st_reg <= st_next;
        end
    end

    // ==========================================================
    // Outputs: lock is immediate on a present cause or a latched code
    assign drive_lock = (st_reg.active != DAL_CODE_NONE) || (cause != DAL_CODE_NONE);
    assign drive_healthy_flag = !drive_lock;
    assign active_alarm_code = st_reg.active;
    assign last_alarm_record = st_reg.last;
    assign reg_rdata = st_reg.rdata;
    assign irq = |(st_reg.irq_stat & st_reg.irq_mask);

    // ==========================================================
    // Checks
    // Lock is held while a code is latched
    chk_lock_follows_code: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        (active_alarm_code != DAL_CODE_NONE) |-> drive_lock)
        else $error("drive not locked with active code");

    // Healthy only with nothing latched and nothing present
    chk_healthy_inverse: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        drive_healthy_flag == (active_alarm_code == DAL_CODE_NONE && cause == DAL_CODE_NONE))
        else $error("healthy flag wrong");

    // First present cause is latched on the next edge
    chk_trip_latches: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        (active_alarm_code == DAL_CODE_NONE && cause != DAL_CODE_NONE && !reset_cmd)
        |=> active_alarm_code == $past(cause))
        else $error("alarm code not latched");

    // A latched code other than undervoltage does not move without reset or restore
    chk_latch_holds: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        (active_alarm_code != DAL_CODE_NONE && active_alarm_code != DAL_CODE_UNDERVOLT
         && !reset_cmd && !restore_defaults_cmd) |=> $stable(active_alarm_code))
        else $error("latched code changed");

    // Accepted reset command zeroes both codes
    chk_reset_clears: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        reset_ok |=> active_alarm_code == DAL_CODE_NONE && last_alarm_record == DAL_CODE_NONE)
        else $error("reset did not clear codes");

    // Parameter checksum code refuses the reset command
    chk_sum_blocks: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        (reset_cmd && active_alarm_code == DAL_CODE_PARAM_SUM && !restore_defaults_cmd)
        |=> active_alarm_code == DAL_CODE_PARAM_SUM)
        else $error("reset acted on checksum alarm");

    // Undervoltage trip leaves the record alone
    chk_uv_no_record: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        (active_alarm_code == DAL_CODE_NONE && cause == DAL_CODE_UNDERVOLT && !reset_cmd)
        |=> $stable(last_alarm_record))
        else $error("undervoltage overwrote record");

    // Without auto-clear undervoltage latches like any alarm
    chk_uv_latch: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        (!st_reg.uv_auto && active_alarm_code == DAL_CODE_UNDERVOLT && !reset_cmd)
        |=> active_alarm_code == DAL_CODE_UNDERVOLT)
        else $error("undervoltage cleared without auto-clear");

    // An unmasked trip raises the interrupt line on the next edge
    chk_irq_level: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        (active_alarm_code == DAL_CODE_NONE && cause != DAL_CODE_NONE && !reset_cmd
         && st_reg.irq_mask[DAL_IRQ_TRIP] && !(reg_wr && reg_addr == DAL_OFS_IRQ_MASK))
        |=> irq)
        else $error("irq level wrong");

    // Program checksum code refuses the reset command too
    chk_plc_sum_blocks: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        (reset_cmd && active_alarm_code == DAL_CODE_PLC_SUM && !restore_defaults_cmd)
        |=> active_alarm_code == DAL_CODE_PLC_SUM)
        else $error("reset acted on program checksum alarm");

    // Any trip other than undervoltage is written to the record
    chk_record_trip: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        (active_alarm_code == DAL_CODE_NONE && cause != DAL_CODE_NONE
         && cause != DAL_CODE_UNDERVOLT && !reset_cmd)
        |=> last_alarm_record == $past(cause))
        else $error("trip not recorded");

    // With auto-clear on, undervoltage drops once supply is back
    chk_uv_auto_clear: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        (st_reg.uv_auto && active_alarm_code == DAL_CODE_UNDERVOLT && !st_reg.flt[1])
        |=> active_alarm_code == DAL_CODE_NONE)
        else $error("undervoltage not auto-cleared");

    // User alarm bits fall only through an accepted reset
    chk_user_sticky: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        !reset_ok |=> (st_reg.user_first || !$past(st_reg.user_first))
        && (st_reg.user_second || !$past(st_reg.user_second)))
        else $error("user alarm bit cleared without reset");

    // Restore with the checksum fault gone moves the code to defaults
    chk_restore_lifts: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        (restore_defaults_cmd && !param_sum_err && !plc_sum_err
         && (active_alarm_code == DAL_CODE_PLC_SUM || active_alarm_code == DAL_CODE_PARAM_SUM))
        |=> active_alarm_code == DAL_CODE_DEFAULTS)
        else $error("restore did not lift checksum code");

    // Only the defined alarm codes are ever shown
    chk_code_legal: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        active_alarm_code <= DAL_CODE_USER_SECOND || active_alarm_code == DAL_CODE_PLC_SUM
        || active_alarm_code == DAL_CODE_PARAM_SUM || active_alarm_code == DAL_CODE_DEFAULTS)
        else $error("undefined alarm code");

    // ==========================================================
    // Cover points
    // Main scenarios: trip, reset, auto-clear, refused reset, user alarm
    cov_trip: cover property (@(posedge clk_sys) disable iff (!resetn)
        active_alarm_code == DAL_CODE_NONE ##1 active_alarm_code == DAL_CODE_OVERCURR);
    cov_reset: cover property (@(posedge clk_sys) disable iff (!resetn) reset_ok);
    cov_uv_auto: cover property (@(posedge clk_sys) disable iff (!resetn)
        st_reg.uv_auto && active_alarm_code == DAL_CODE_UNDERVOLT
        ##1 active_alarm_code == DAL_CODE_NONE);
    cov_sum_block: cover property (@(posedge clk_sys) disable iff (!resetn)
        reset_cmd && !reset_ok);
    cov_user_trip: cover property (@(posedge clk_sys) disable iff (!resetn)
        active_alarm_code == DAL_CODE_NONE ##1 active_alarm_code == DAL_CODE_USER_FIRST);
endmodule
`default_nettype wire
